// file: utrd_map.vh
`ifndef UTRD_MAP_VH
`define UTRD_MAP_VH
// Register word offsets (one 32-bit word each)
`define UTRD_ADR_DATA     4'h0
`define UTRD_ADR_STATUS   4'h1
`define UTRD_ADR_CTRL     4'h2
`define UTRD_ADR_BAUD     4'h3
`define UTRD_ADR_COUNT    4'h4
// Status bit positions
`define UTRD_ST_TXE       0
`define UTRD_ST_TRANSMITTER_IDLE_FLAG     1
`define UTRD_ST_RXA       2
`define UTRD_ST_RECEIVER_IDLE_FLAG     3
`define UTRD_ST_OVR       4
`define UTRD_ST_FRAMING_ERROR_FLAG      5
// Control bit positions
`define UTRD_CT_TRANSMITTER_ENABLE      0
`define UTRD_CT_RECEIVER_ENABLE      1
`define UTRD_CT_NINE      2
`define UTRD_CT_STOP2     3
`define UTRD_CT_BRK       4
`define UTRD_CT_TX_EMPTY_IRQ_ENABLE      5
`define UTRD_CT_RIE       6
`define UTRD_CT_TX9       7
`define UTRD_CT_TRIG      9:8
// Reset values
`define UTRD_BAUD_RST     16'h0019
`define UTRD_CTRL_RST     10'h000
// Timing counts and FIFO depth
`define UTRD_OVS          16
`define UTRD_BRK_BITS     13
`define UTRD_FIFO_DEPTH   4
`endif

// file: utrd_rx_fifo.v
`default_nettype none
// Four-entry receive store with occupancy count
module utrd_rx_fifo #(
	parameter W     = 10,
	parameter DEPTH = 4,
	parameter AW    = 2
)(
	input  wire          clk_i,
	input  wire          rst_i,
	input  wire          clr_i,
	input  wire          push_i,
	input  wire [W-1:0]  wdata_i,
	input  wire          pop_i,
	output wire [W-1:0]  rdata_o,
	output wire          full_o,
	output wire          empty_o,
	output wire [AW:0]   count_o
);
	reg [W-1:0] mem_q [0:DEPTH-1]; // Entry storage
	reg [AW-1:0] wp_q;             // Write index
	reg [AW-1:0] rp_q;             // Read index
	reg [AW:0]   cnt_q;            // Occupancy
	wire do_push;
	wire do_pop;
	assign full_o  = (cnt_q == DEPTH[AW:0]);
	assign empty_o = (cnt_q == {(AW+1){1'b0}});
	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;
	assign rdata_o = mem_q[rp_q];
	assign count_o = cnt_q;
	// Pointer and count update
	always @(posedge clk_i)
	begin
		if (rst_i || clr_i)
		begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_push)
				wp_q <= wp_q + 1'b1;
			if (do_pop)
				rp_q <= rp_q + 1'b1;
			if (do_push && !do_pop)
				cnt_q <= cnt_q + 1'b1;
			else if (do_pop && !do_push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
	// Entry writes, one per index
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1)
		begin : g_ent
			localparam [AW-1:0] IDX = gi; // Entry index at pointer width
			always @(posedge clk_i)
			begin
				if (do_push && wp_q == IDX)
					mem_q[gi] <= wdata_i;
			end
		end
	endgenerate
endmodule // utrd_rx_fifo
`default_nettype wire

// file: utrd_top.v
// Operation
// - Transmit LSB first, ninth bit from control
// - Ignore data writes while buffer not empty
// - Status access then data write clears empty
// - Empty flag set when buffer free; irq
// - Write during frame waits until frame ends
// - Write while idle loads shifter, starts immediately
// - Idle flag set at frame end; same clear
// - Break request held past divisor plus one
// - Break is start, 13N zeros, stop_bit_count_select
// - Breaks repeat; after clear send stop_bit_count_select
// - Break frames raise no transmit interrupt
// - Receive LSB first; ninth bit stored
// - Sixteen-times oversampling, three-sample majority
// - Stop sampled, word moves into buffer
// - Four-entry FIFO; fifth word overrun drops
// - Enabled receiver hunts for start bit
// - Data-available flag and byte count readable
// - Receive irq on trigger level, overrun
// - Status access then data read clears available
// - Break received: zeros, framing error, idle
// - After break wait for high line
// - Receiver idle low during frame only
// - Every stop bit high, else framing error; the receiver checks only the first stop bit
//
// Our own choices: the register offsets and the Wishbone register port.
`include "utrd_map.vh"
`default_nettype none
module utrd_top #(
	parameter DIV_RST = 16'h0019
)(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        rx_i,
	output reg         tx_o,
	output reg         irq_o
);
	// Transmit states
	localparam TS_IDLE = 3'b001;
	localparam TS_SEND = 3'b010;
	localparam TS_STOP = 3'b100;
	// Break length in bit times, sized to the bit counter
	localparam [5:0] BRK_LEN = `UTRD_BRK_BITS;
	// Receive states
	localparam RS_HUNT = 4'b0001;
	localparam RS_CONF = 4'b0010;
	localparam RS_DATA = 4'b0100;
	localparam RS_WAIT = 4'b1000;

	reg  [9:0]  ctrl_q;        // Control register
	reg  [15:0] div_q;         // Baud divisor
	reg  [15:0] bdiv_q;        // Oversample divider
	reg         os_tick;       // One-cycle 16x enable
	reg         stat_seen_q;   // Status access armed clear sequence
	reg         txe_q;         // Transmit buffer empty flag
	reg         transmitter_idle_flag_q;       // Transmitter idle flag
	reg  [8:0]  txbuf_q;       // Pending transmit word
	reg  [2:0]  ts_q;          // Transmit state
	reg  [11:0] tsh_q;         // Transmit shifter incl stop
	reg  [5:0]  tbits_q;       // Bits left in frame
	reg  [3:0]  tos_q;         // Oversample count in tx bit
	reg         tbrk_q;        // Frame in progress is a break
	reg  [16:0] brk_cnt_q;     // Break request hold counter
	reg         brk_arm_q;     // Next frame will be a break
	reg         rx_s1_q;       // Synchroniser stage one
	reg         rx_s2_q;       // Synchroniser stage two
	reg  [2:0]  rx_hist_q;     // Three samples for vote
	reg  [3:0]  rs_q;          // Receive state
	reg  [3:0]  ros_q;         // Oversample phase
	reg  [3:0]  rbits_q;       // Bits received
	reg  [8:0]  rsh_q;         // Receive shifter
	reg         rxa_q;         // Data available flag
	reg         ovr_q;         // Overrun flag
	reg         framing_error_flag_q;        // Framing error flag
	reg         receiver_idle_flag_q;       // Receiver idle flag
	reg         rx9_q;         // Ninth received bit of head word
	reg         push_q;        // FIFO push strobe
	reg  [9:0]  pushd_q;       // Word plus framing bit
	reg         ev_rx_q;       // Receive irq event
	wire        vote;
	wire        acc;
	wire        dat_wr;
	wire        dat_rd;
	wire        st_rd;
	wire [9:0]  fifo_rd;
	wire        fifo_full;
	wire        fifo_empty;
	wire [2:0]  fifo_cnt;
	wire [3:0]  nbits;
	wire [2:0]  trig_lvl;
	reg  [31:0] rd_mux;

	// Bus strobes, one per access
	assign acc    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign dat_wr = acc && wb_we_i && wb_sel_i[0] && wb_adr_i == `UTRD_ADR_DATA;
	assign dat_rd = acc && !wb_we_i && wb_adr_i == `UTRD_ADR_DATA;
	assign st_rd  = acc && wb_adr_i == `UTRD_ADR_STATUS;
	assign nbits  = ctrl_q[`UTRD_CT_NINE] ? 4'h9 : 4'h8;
	assign trig_lvl = {1'b0, ctrl_q[`UTRD_CT_TRIG]} + 3'h1;
	// Majority of the three latest samples
	assign vote = (rx_hist_q[0] & rx_hist_q[1]) | (rx_hist_q[0] & rx_hist_q[2])
		| (rx_hist_q[1] & rx_hist_q[2]);

	// Oversample divider; one pulse per divisor+1 clocks
	always @(posedge clk_i)
	begin
		// Compare with >= so that lowering the divisor below the count cannot stall
		if (rst_i || bdiv_q >= div_q)
			bdiv_q <= 16'h0000;
		else
			bdiv_q <= bdiv_q + 16'h0001;
		os_tick <= !rst_i && (bdiv_q >= div_q);
	end

	// Register writes and the status-then-data arming
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q      <= `UTRD_CTRL_RST;
			div_q       <= DIV_RST;
			stat_seen_q <= 1'b0;
		end
		else
		begin
			if (acc && wb_we_i && wb_adr_i == `UTRD_ADR_CTRL && wb_sel_i[0])
				ctrl_q[7:0] <= wb_dat_i[7:0];
			if (acc && wb_we_i && wb_adr_i == `UTRD_ADR_CTRL && wb_sel_i[1])
				ctrl_q[9:8] <= wb_dat_i[9:8];
			if (acc && wb_we_i && wb_adr_i == `UTRD_ADR_BAUD && wb_sel_i[0])
				div_q[7:0] <= wb_dat_i[7:0];
			if (acc && wb_we_i && wb_adr_i == `UTRD_ADR_BAUD && wb_sel_i[1])
				div_q[15:8] <= wb_dat_i[15:8];
			// Status access arms; any data access disarms
			if (st_rd)
				stat_seen_q <= 1'b1;
			else if (acc && wb_adr_i == `UTRD_ADR_DATA)
				stat_seen_q <= 1'b0;
		end
	end

	// Break request hold timer: must exceed divisor+1 clocks
	always @(posedge clk_i)
	begin
		if (rst_i || !ctrl_q[`UTRD_CT_BRK])
		begin
			brk_cnt_q <= 17'h00000;
			brk_arm_q <= 1'b0;
		end
		else
		begin
			if (transmitter_idle_flag_q && brk_cnt_q <= {1'b0, div_q} + 17'h00001)
				brk_cnt_q <= brk_cnt_q + 17'h00001;
			if (brk_cnt_q > {1'b0, div_q} + 17'h00001)
				brk_arm_q <= 1'b1;
		end
	end

	// Transmitter
	always @(posedge clk_i)
	begin
		if (rst_i || !ctrl_q[`UTRD_CT_TRANSMITTER_ENABLE])
		begin
			ts_q    <= TS_IDLE;
			txe_q   <= 1'b1;
			transmitter_idle_flag_q <= 1'b1;
			tx_o    <= 1'b1;
			tsh_q   <= 12'hFFF;
			tbits_q <= 6'h00;
			tos_q   <= 4'h0;
			tbrk_q  <= 1'b0;
			txbuf_q <= 9'h000;
		end
		else
		begin
			// Data write accepted only while buffer empty
			if (dat_wr && txe_q)
			begin
				if (stat_seen_q)
					transmitter_idle_flag_q <= 1'b0;
				if (ts_q == TS_IDLE && !brk_arm_q)
				begin
					// Straight into shifter, flag stays set
					tsh_q   <= {3'b111, ctrl_q[`UTRD_CT_TX9], wb_dat_i[7:0]};
					ts_q    <= TS_SEND;
					tbits_q <= {2'b00, nbits} + 6'h01;
					tos_q   <= 4'h0;
					tx_o    <= 1'b0;
					transmitter_idle_flag_q <= 1'b0;
				end
				else
				begin
					// Held until current frame ends
					txbuf_q <= {ctrl_q[`UTRD_CT_TX9], wb_dat_i[7:0]};
					if (stat_seen_q)
						txe_q <= 1'b0;
				end
			end
			case (ts_q)
				TS_IDLE:
				begin
					// Line already high here; a direct load above must keep its start bit
					// Break frame when armed: start bit plus thirteen zeros
					if (brk_arm_q && os_tick)
					begin
						ts_q    <= TS_SEND;
						tbrk_q  <= 1'b1;
						tsh_q   <= 12'h000;
						tbits_q <= BRK_LEN + 6'h01;
						tos_q   <= 4'h0;
						tx_o    <= 1'b0;
						transmitter_idle_flag_q <= 1'b0;
					end
					else if (!txe_q)
					begin
						// Word buffered as the last frame ended goes out now
						tsh_q   <= {3'b111, txbuf_q};
						tbits_q <= {2'b00, nbits} + 6'h01;
						tos_q   <= 4'h0;
						ts_q    <= TS_SEND;
						tx_o    <= 1'b0;
						txe_q   <= 1'b1;
						transmitter_idle_flag_q <= 1'b0;
					end
				end
				TS_SEND:
				begin
					if (os_tick)
					begin
						tos_q <= tos_q + 4'h1;
						if (tos_q == 4'hF)
						begin
							if (tbits_q == 6'h01)
							begin
								// Break repeats while request holds
								if (tbrk_q && ctrl_q[`UTRD_CT_BRK])
									tbits_q <= BRK_LEN;
								else
								begin
									ts_q    <= TS_STOP;
									tbits_q <= ctrl_q[`UTRD_CT_STOP2] ? 6'h02 : 6'h01;
									tx_o    <= 1'b1;
								end
							end
							else
							begin
								// LSB first shift out
								tbits_q <= tbits_q - 6'h01;
								tx_o    <= tbrk_q ? 1'b0 : tsh_q[0];
								tsh_q   <= {1'b1, tsh_q[11:1]};
							end
						end
					end
				end
				TS_STOP:
				begin
					tx_o <= 1'b1;
					if (os_tick && tos_q == 4'hF)
					begin
						tos_q <= 4'h0;
						if (tbits_q == 6'h01)
						begin
							tbrk_q <= 1'b0;
							if (!txe_q)
							begin
								// Buffered word moves in; buffer empty again
								tsh_q   <= {3'b111, txbuf_q};
								tbits_q <= {2'b00, nbits} + 6'h01;
								ts_q    <= TS_SEND;
								tx_o    <= 1'b0;
								txe_q   <= 1'b1;
							end
							else
							begin
								ts_q    <= TS_IDLE;
								transmitter_idle_flag_q <= 1'b1;
							end
						end
						else
							tbits_q <= tbits_q - 6'h01;
					end
					else if (os_tick)
						tos_q <= tos_q + 4'h1;
				end
				default:
					ts_q <= TS_IDLE;
			endcase
		end
	end

	// Receive line synchroniser and sample history
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_s1_q   <= 1'b1;
			rx_s2_q   <= 1'b1;
			rx_hist_q <= 3'b111;
		end
		else
		begin
			rx_s1_q <= rx_i;
			rx_s2_q <= rx_s1_q;
			if (os_tick)
				rx_hist_q <= {rx_hist_q[1:0], rx_s2_q};
		end
	end

	// Receiver sequencing
	always @(posedge clk_i)
	begin
		push_q <= 1'b0;
		if (rst_i || !ctrl_q[`UTRD_CT_RECEIVER_ENABLE])
		begin
			rs_q    <= RS_HUNT;
			ros_q   <= 4'h0;
			rbits_q <= 4'h0;
			rsh_q   <= 9'h000;
			receiver_idle_flag_q <= 1'b1;
			pushd_q <= 10'h000;
		end
		else if (os_tick)
		begin
			case (rs_q)
				RS_HUNT:
				begin
					// Hunt for low start level
					if (!vote)
					begin
						rs_q    <= RS_CONF;
						ros_q   <= 4'h0;
						receiver_idle_flag_q <= 1'b0;
					end
				end
				RS_CONF:
				begin
					ros_q <= ros_q + 4'h1;
					if (ros_q == 4'h6)
					begin
						// Still low at mid-bit confirms start
						if (!vote)
						begin
							rs_q    <= RS_DATA;
							ros_q   <= 4'h0;
							rbits_q <= 4'h0;
						end
						else
						begin
							rs_q    <= RS_HUNT;
							receiver_idle_flag_q <= 1'b1;
						end
					end
				end
				RS_DATA:
				begin
					ros_q <= ros_q + 4'h1;
					if (ros_q == 4'hF)
					begin
						// One shift per bit time
						if (rbits_q == nbits)
						begin
							// Stop bit sampled: store word, error if low
							push_q  <= 1'b1;
							pushd_q <= {!vote, ctrl_q[`UTRD_CT_NINE] ? rsh_q
								: {1'b0, rsh_q[8:1]}};
							receiver_idle_flag_q <= 1'b1;
							// Low stop means break or error: wait for high
							rs_q    <= vote ? RS_HUNT : RS_WAIT;
						end
						else
						begin
							// LSB first into shifter
							rsh_q   <= {vote, rsh_q[8:1]};
							rbits_q <= rbits_q + 4'h1;
						end
					end
				end
				RS_WAIT:
				begin
					if (vote)
						rs_q <= RS_HUNT;
				end
				default:
					rs_q <= RS_HUNT;
			endcase
		end
	end

	// Receive store
	utrd_rx_fifo #(
		.W     (10),
		.DEPTH (`UTRD_FIFO_DEPTH),
		.AW    (2)
	) u_fifo (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clr_i   (!ctrl_q[`UTRD_CT_RECEIVER_ENABLE]),
		.push_i  (push_q),
		.wdata_i (pushd_q),
		.pop_i   (dat_rd),
		.rdata_o (fifo_rd),
		.full_o  (fifo_full),
		.empty_o (fifo_empty),
		.count_o (fifo_cnt)
	);

	// Receive flags; set wins over clear
	always @(posedge clk_i)
	begin
		ev_rx_q <= 1'b0;
		if (rst_i || !ctrl_q[`UTRD_CT_RECEIVER_ENABLE])
		begin
			rxa_q  <= 1'b0;
			ovr_q  <= 1'b0;
			framing_error_flag_q <= 1'b0;
			rx9_q  <= 1'b0;
		end
		else
		begin
			rx9_q  <= fifo_rd[8] && !fifo_empty;
			framing_error_flag_q <= fifo_rd[9] && !fifo_empty;
			if (dat_rd && stat_seen_q)
			begin
				rxa_q <= 1'b0;
				ovr_q <= 1'b0;
			end
			if (push_q && fifo_full)
			begin
				ovr_q   <= 1'b1; // Fifth word dropped
				ev_rx_q <= 1'b1;
			end
			if (push_q && !fifo_full && fifo_cnt + 3'h1 == trig_lvl)
				ev_rx_q <= 1'b1;
			if (!fifo_empty && !(dat_rd && fifo_cnt == 3'h1))
				rxa_q <= 1'b1;
			else if (fifo_empty)
				rxa_q <= 1'b0;
		end
	end

	// Interrupt: tx empty (never during break) or rx event
	always @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= (ctrl_q[`UTRD_CT_TX_EMPTY_IRQ_ENABLE] && txe_q && ctrl_q[`UTRD_CT_TRANSMITTER_ENABLE] && !tbrk_q)
				|| (ctrl_q[`UTRD_CT_RIE] && (ev_rx_q || ovr_q
				|| {1'b0, fifo_cnt} >= {1'b0, trig_lvl}));
	end

	// Read multiplexer; unmapped reads zero
	always @*
	begin
		rd_mux = 32'h00000000;
		case (wb_adr_i)
			`UTRD_ADR_DATA:   rd_mux = {23'h000000, fifo_empty ? 9'h000 : fifo_rd[8:0]};
			`UTRD_ADR_STATUS: rd_mux = {25'h0000000, rx9_q, framing_error_flag_q, ovr_q, receiver_idle_flag_q,
				rxa_q, transmitter_idle_flag_q, txe_q};
			`UTRD_ADR_CTRL:   rd_mux = {22'h000000, ctrl_q};
			`UTRD_ADR_BAUD:   rd_mux = {16'h0000, div_q};
			`UTRD_ADR_COUNT:  rd_mux = {29'h00000000, fifo_cnt};
			default:          rd_mux = 32'h00000000;
		endcase
	end

	// Wishbone ack one cycle after request, dropped next cycle
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= acc;
			wb_dat_o <= acc ? rd_mux : 32'h00000000;
		end
	end
endmodule // utrd_top
`default_nettype wire

// file: utrd_top_sva.sv
`include "utrd_map.vh"
`default_nettype none
// Handshake, line and readback checks on the top ports
module utrd_top_sva #(
	parameter DIV_RST = 16'h0019
)(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        rx_i,
	input wire logic        tx_o,
	input wire logic        irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Taken request answered at the next edge
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	// Ack lasts one cycle and only answers a request
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	// Read data is zero outside the ack cycle
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("data outside ack");
	// Outputs at rest just after reset
	chk_tx_rst: assert property ($fell(rst_i) |-> tx_o && !wb_ack_o)
		else $error("line busy after reset");
	chk_irq_rst: assert property ($fell(rst_i) |-> !irq_o)
		else $error("irq after reset");
	// A start bit is never shorter than half the shortest bit
	chk_start_len: assert property ($fell(tx_o) |-> !tx_o [*8])
		else $error("start bit short");
	// Byte count readback never exceeds the store depth
	chk_count_max: assert property (wb_ack_o && $past({wb_we_i, wb_adr_i}) == 5'h04 |->
		wb_dat_o <= 32'h4)
		else $error("count above depth");
	// Unmapped reads return zero
	chk_unmapped: assert property (wb_ack_o && $past({wb_we_i, wb_adr_i}) inside {[5'h05:5'h0F]}
		|-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule // utrd_top_sva
bind utrd_top utrd_top_sva #(.DIV_RST(DIV_RST)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i), .tx_o(tx_o), .irq_o(irq_o)
);
`default_nettype wire

// file: utrd_peer.sv
`default_nettype none
// Remote serial device: drives receive line, captures transmit frames
module utrd_peer #(
	parameter int BT = 16
)(
	input  wire logic clk_i,
	input  wire logic tx_i,
	output var  logic rx_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int         nrx    = 8;   // Data bits per captured frame
	int         run    = 0;   // Current low run on the line
	int         maxrun = 0;   // Longest low run seen
	logic [9:0] got[$];       // Frames, stop bit above data
	logic [9:0] f;            // Frame being captured
	initial rx_o = 1'b1;      // Line idles high
	// Start, data LSB first, one stop, then idle high
	task automatic send(input logic [8:0] d, input int nb);
		@(posedge clk_i);
		rx_o <= 1'b0;
		repeat (BT) @(posedge clk_i);
		for (int i = 0; i < nb; i++)
		begin
			rx_o <= d[i];
			repeat (BT) @(posedge clk_i);
		end
		rx_o <= 1'b1;
		repeat (BT) @(posedge clk_i);
	endtask
	// Line low for n clocks, then a high stop level
	task automatic low(input int n);
		@(posedge clk_i);
		rx_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		rx_o <= 1'b1;
		repeat (2 * BT) @(posedge clk_i);
	endtask
	// Sample each bit mid-cell after a falling edge
	always
	begin
		@(negedge tx_i);
		repeat (BT / 2) @(posedge clk_i);
		f = 10'h0;
		for (int i = 0; i <= nrx; i++)
		begin
			repeat (BT) @(posedge clk_i);
			f[i] = tx_i;
		end
		got.push_back(f);
	end
	// Longest low run, for break length
	always @(posedge clk_i)
	begin
		if (tx_i === 1'b0)
			run <= run + 1;
		else
		begin
			if (run > maxrun)
				maxrun <= run;
			run <= 0;
		end
	end
endmodule // utrd_peer
`default_nettype wire

// file: utrd_top_bench.sv
`include "utrd_map.vh"
`default_nettype none
// Drives the bus and the remote device, judges the data of every rd reply
module utrd_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] AD = `UTRD_ADR_DATA;
	localparam logic [3:0] AS = `UTRD_ADR_STATUS;
	localparam logic [3:0] AC = `UTRD_ADR_CTRL;
	localparam logic [3:0] AN = `UTRD_ADR_COUNT;
	localparam int         BT = `UTRD_OVS;   // Clocks a bit at divisor 0
	logic        clk_i    = 1'b0;
	logic        rst_i    = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i  = 1'b0;
	logic [3:0]  wb_adr_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        rx_i;
	logic        tx_o;
	logic        irq_o;
	logic [31:0] q;                 // Data of the last bus cycle
	int          failures  = 0;
	int          cmp_count = 0;
	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;
	utrd_top #(.DIV_RST(`UTRD_BAUD_RST)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i), .tx_o(tx_o), .irq_o(irq_o)
	);
	utrd_peer #(.BT(BT)) peer (.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i));
	// Masked compare
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
		cmp_count++;
		if ((g & m) !== (e & m))
		begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, g & m, e & m);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// One classic cycle, data taken at the ack edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
			chk(32'h0, 32'h1, 32'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, 32'h0);
		chk(q, e, m);
	endtask
	task automatic ck_irq(input logic e);
		chk({31'h0, irq_o}, {31'h0, e}, 32'h1);
	endtask
	// Reset values, unmapped read, then fast divisor
	task automatic t_rst;
		rd(`UTRD_ADR_BAUD, 32'h19, 32'hFFFF);
		rd(AS, 32'h0B, 32'h3F);
		rd(4'hF, 32'h0, 32'hFFFFFFFF);
		ck_irq(1'b0);
		bus(1'b1, `UTRD_ADR_BAUD, 32'h0);
		bus(1'b1, AC, 32'h3);
	endtask
	// Direct load, buffered word, refused word, ninth bit
	task automatic t_tx;
		rd(AS, 32'h3, 32'h3);
		bus(1'b1, AD, 32'hA5);
		rd(AS, 32'h1, 32'h3);
		bus(1'b1, AD, 32'h3C);
		rd(AS, 32'h0, 32'h1);
		bus(1'b1, AD, 32'hFF);
		cy(24 * BT);
		chk(32'(peer.got.size()), 32'h2, 32'hFF);
		chk({22'h0, peer.got[0]}, 32'h1A5, 32'h3FF);
		chk({22'h0, peer.got[1]}, 32'h13C, 32'h3FF);
		rd(AS, 32'h3, 32'h3);
		bus(1'b1, AC, 32'h87);
		peer.nrx = 9;
		bus(1'b0, AS, 32'h0);
		bus(1'b1, AD, 32'h55);
		cy(13 * BT);
		chk({22'h0, peer.got[2]}, 32'h355, 32'h3FF);
		peer.nrx = 8;
	endtask
	// Glitch, trigger level, overrun, drain
	task automatic t_rx;
		logic [7:0] v [5] = '{8'h00, 8'hFF, 8'h5A, 8'h81, 8'h7E};
		bus(1'b1, AC, 32'h343);
		peer.low(4);
		rd(AN, 32'h0, 32'h7);
		for (int i = 0; i < 5; i++)
		begin
			peer.send({1'b0, v[i]}, 8);
			cy(4);
			if (i == 2)
				ck_irq(1'b0);
			if (i == 3)
				ck_irq(1'b1);
		end
		rd(AN, 32'h4, 32'h7);
		rd(AS, 32'h1C, 32'h3C);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b0, AS, 32'h0);
			rd(AD, {24'h0, v[i]}, 32'hFF);
		end
		rd(AS, 32'h8, 32'h1C);
		ck_irq(1'b0);
	endtask
	// Nine-bit word, received break, recovery after it
	task automatic t_rbrk;
		bus(1'b1, AC, 32'h47);
		fork
			peer.send(9'h1AA, 9);
			begin
				cy(5 * BT);
				rd(AS, 32'h0, 32'h8);
			end
		join
		cy(4);
		ck_irq(1'b1);
		rd(AS, 32'h4C, 32'h6C);
		rd(AD, 32'hAA, 32'hFF);
		peer.low(14 * BT);
		rd(AN, 32'h1, 32'h7);
		rd(AS, 32'h2C, 32'h2C);
		rd(AD, 32'h0, 32'hFF);
		peer.send(9'h033, 9);
		cy(4);
		rd(AD, 32'h33, 32'hFF);
	endtask
	// Held break request, masked irq, stop_bit_count_select after release
	task automatic t_tbrk;
		bus(1'b1, AC, 32'h33);
		cy(75 * BT);
		ck_irq(1'b0);
		bus(1'b1, AC, 32'h23);
		cy(25 * BT);
		ck_irq(1'b1);
		chk({31'h0, tx_o}, 32'h1, 32'h1);
		chk(32'(peer.maxrun >= 14 * BT), 32'h1, 32'h1);
		chk(32'(((peer.maxrun + BT / 2) / BT - 1) % 13), 32'h0, 32'hFF);
		rd(AS, 32'h3, 32'h3);
	endtask
	// Print counts and verdict, then stop
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		cy(16);
		rst_i <= 1'b0;
		t_rst();
		t_tx();
		t_rx();
		t_rbrk();
		t_tbrk();
		final_report();
	end
	// Watchdog
	initial
	begin
		cy(20000);
		failures++;
		final_report();
	end
endmodule // utrd_top_bench
`default_nettype wire
